/* File: pkg/flash_map_pkg.sv */
`default_nettype none
package flash_map_pkg;
  // =====================================================================
  // Address layout
  localparam int ADDR_W            = 24;
  localparam int SECTOR_BITS       = 12;
  localparam int SECTOR_IDX_W      = 11;
  localparam int SECTORS_32M       = 1024;
  localparam int SECTORS_64M       = 2048;
  localparam logic [23:0] LAST_BYTE_32M = 24'h3F_FFFF;
  localparam logic [23:0] LAST_BYTE_64M = 24'h7F_FFFF;
  localparam int REGION_COUNT      = 4;
  localparam int REGION_BYTES      = 256;
  localparam int REGION_SEL_LSB    = 12;
  localparam int REGION_OFS_W      = 8;
  localparam logic [23:0] REGION_STRIDE = 24'h00_1000;
  localparam logic [3:0]  LOCK_RESET    = 4'h1;
  // =====================================================================
  // Parameter table content
  localparam logic [7:0] SIG_B0        = 8'h53;
  localparam logic [7:0] SIG_B1        = 8'h46;
  localparam logic [7:0] SIG_B2        = 8'h44;
  localparam logic [7:0] SIG_B3        = 8'h50;
  localparam logic [7:0] REV_MINOR     = 8'h00;
  localparam logic [7:0] REV_MAJOR     = 8'h01;
  localparam logic [7:0] HDR_COUNT     = 8'h02;
  localparam logic [7:0] RSVD_BYTE     = 8'hFF;
  localparam logic [7:0] JEDEC_ID      = 8'h00;
  localparam logic [7:0] JEDEC_LEN     = 8'h09;
  localparam logic [23:0] JEDEC_PTR    = 24'h00_0080;
  // Arbitrary neutral vendor identifier.
  localparam logic [7:0] VENDOR_ID     = 8'hA5;
  localparam logic [7:0] VENDOR_LEN    = 8'h04;
  localparam logic [7:0] ERASE_INFO    = 8'hE5;
  localparam logic [7:0] ERASE4K_OP    = 8'h20;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  // =====================================================================
  // Command codes on the access port
  typedef enum logic [1:0] {
    CMD_READ  = 2'b00,
    CMD_PROG  = 2'b01,
    CMD_ERASE = 2'b11,
    CMD_LOCK  = 2'b10
  } cmd_e;
  typedef enum logic [1:0] {
    SPACE_MAIN = 2'b00,
    SPACE_SEC  = 2'b01,
    SPACE_SFDP = 2'b11
  } space_e;
endpackage
`default_nettype wire

/* File: logic/sfdp_rom.sv */
`timescale 1ns/1ns
`default_nettype none
module sfdp_rom
  import flash_map_pkg::*;
(
  input  wire logic [7:0] addr,
  output logic      [7:0] data
);
  // =====================================================================
  // Fixed region 0 content
  always_comb
  begin
    unique case (addr)
      8'h00: data = SIG_B0; // R10
      8'h01: data = SIG_B1; // R10
      8'h02: data = SIG_B2; // R10
      8'h03: data = SIG_B3; // R10
      8'h04: data = REV_MINOR; // R11
      8'h05: data = REV_MAJOR; // R11
      8'h06: data = HDR_COUNT; // R11
      8'h08: data = JEDEC_ID; // R12
      8'h09: data = REV_MINOR; // R12
      8'h0A: data = REV_MAJOR; // R12
      8'h0B: data = JEDEC_LEN; // R12
      8'h0C: data = JEDEC_PTR[7:0]; // R12
      8'h0D: data = JEDEC_PTR[15:8]; // R12
      8'h0E: data = JEDEC_PTR[23:16]; // R12
      8'h10: data = VENDOR_ID; // R13
      8'h11: data = REV_MINOR; // R13
      8'h12: data = REV_MAJOR; // R13
      8'h13: data = VENDOR_LEN; // R13
      8'h80: data = ERASE_INFO;
      8'h81: data = ERASE4K_OP; // R14
      default: data = RSVD_BYTE; // R11
    endcase
  end
endmodule
`default_nettype wire

/* File: logic/flash_address_map.sv */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1 - Each auxiliary space is addressed with a full 24-bit address though little of it holds data.
// R2 - The main array is split only into 4-kilobyte erase sectors.
// R3 - Sectors sit on 4-kilobyte boundaries and the upper address bits pick the sector.
// R4 - The small variant has 1024 sectors up to 3FFFFFh, the large one 2048 up to 7FFFFFh.
// R5 - Four 256-byte security regions sit at k times 1000h, each FFh bytes long beyond its base.
// R6 - A region whose one-time lock bit is programmed stays protected for good; the code clears the lock bits of regions 1 to 3 on reset.
// R7 - Regions 1 to 3 are erased, programmed and locked each on its own.
// R8 - Region 0 holds factory-locked parameter data returned by the parameter read.
// R9 - The parameter read returns the 256 bytes of region 0 in the standard layout.
// R10 - Bytes 00h to 03h hold the signature 53h 46h 44h 50h.
// R11 - Bytes 04h to 07h hold revision 00h, 01h, header count 02h and FFh.
// R12 - The first header at 08h holds id 00h, version 1.0, length 09h, pointer 000080h and FFh.
// R13 - The second header at 10h holds a vendor id, revision 1.0 and length 04h at 13h.
// R14 - Byte 81h holds the 4-kilobyte erase opcode 20h.
// R15 - Program or erase aimed at a locked region is ignored and the content is kept.
module flash_address_map
  import flash_map_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        large_variant,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_cmd,
  input  wire logic [1:0]  req_space,
  input  wire logic [23:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             rsp_valid,
  output logic      [7:0]  rsp_rdata,
  output logic             rsp_hit,
  output logic             main_valid,
  output logic      [10:0] main_sector,
  output logic      [11:0] main_offset,
  output logic      [3:0]  lock_bits,
  output logic             refused
);
  // =====================================================================
  // Decode
  logic [1:0]  region;
  logic [7:0]  rofs;
  logic        region_hit;
  logic        main_hit;
  logic [7:0]  rom_data;
  logic [7:0]  sec_mem [REGION_COUNT][REGION_BYTES];
  logic        strap_sync;
  logic        variant;

  logic        sec_req;
  logic        main_req;
  logic        locked_tgt;
  logic [3:0]  region_sel;
  logic [3:0]  lock_set;
  logic [3:0]  prog_en;
  logic [3:0]  erase_en;
  logic        next_hit;
  logic [7:0]  next_rdata;

  assign region     = req_addr[REGION_SEL_LSB +: 2]; // R5
  assign rofs       = req_addr[REGION_OFS_W-1:0]; // R5
  assign region_hit = (req_addr[ADDR_W-1:REGION_SEL_LSB+2] == '0) &&
                      (req_addr[REGION_SEL_LSB-1:REGION_OFS_W] == '0); // R1 R5
  assign main_hit   = variant ? (req_addr <= LAST_BYTE_64M)
                              : (req_addr <= LAST_BYTE_32M); // R4
  assign sec_req    = req_valid && (req_space == SPACE_SEC);
  assign main_req   = req_valid && (req_space == SPACE_MAIN);
  assign locked_tgt = region_hit && lock_bits[region];

  // Region 0 answers from the fixed table in both spaces, so its flop copy is never read.
  sfdp_rom u_rom
  (
    .addr (req_addr[7:0]),
    .data (rom_data)
  );

  // =====================================================================
  // Variant strap
  // The strap arrives from a pin, so a first stage settles it before the capture flop.
  always_ff @(posedge clk)
  begin
    strap_sync <= large_variant;
  end

  // Held outside reset, so a strap that moves in service never remaps the array.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      variant <= strap_sync; // R4
  end

  // =====================================================================
  // Per-region lock and storage
  for (genvar k = 0; k < REGION_COUNT; k++)
  begin : g_region
    assign region_sel[k] = region_hit && (region == 2'(k));
    assign lock_set[k]   = sec_req && region_sel[k] && (req_cmd == CMD_LOCK); // R7
    assign prog_en[k]    = sec_req && region_sel[k] && !lock_bits[k] &&
                           (req_cmd == CMD_PROG); // R15 R7
    assign erase_en[k]   = sec_req && region_sel[k] && !lock_bits[k] &&
                           (req_cmd == CMD_ERASE); // R15 R7

    // A lock bit is only ever raised here; the reset value stands for a fresh part.
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        lock_bits[k] <= LOCK_RESET[k]; // R8
      else if (lock_set[k])
        lock_bits[k] <= 1'b1; // R6
    end

    // Programming only clears bits; erase and reset are the only ways back to all ones.
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        for (int b = 0; b < REGION_BYTES; b++)
          sec_mem[k][b] <= ERASED_BYTE;
      end
      else if (prog_en[k])
        sec_mem[k][rofs] <= sec_mem[k][rofs] & req_wdata; // R7
      else if (erase_en[k])
      begin
        for (int b = 0; b < REGION_BYTES; b++)
          sec_mem[k][b] <= ERASED_BYTE; // R7
      end
    end
  end

  // =====================================================================
  // Read data and hit flag
  // Space code 10 maps nothing; it reads as a miss instead of aliasing the main array.
  always_comb
  begin
    next_hit   = 1'b0;
    next_rdata = ERASED_BYTE;
    unique case (req_space)
      SPACE_MAIN:
      begin
        next_hit = main_hit; // R4
      end
      SPACE_SEC:
      begin
        next_hit = region_hit; // R5
        if (region_sel[0])
          next_rdata = rom_data; // R8
        else if (region_hit)
          next_rdata = sec_mem[region][rofs]; // R7
      end
      SPACE_SFDP:
      begin
        next_hit = region_sel[0]; // R9
        if (region_sel[0])
          next_rdata = rom_data; // R9
      end
      default:
      begin
        next_hit   = 1'b0;
        next_rdata = ERASED_BYTE;
      end
    endcase
  end

  // =====================================================================
  // Response strobes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rsp_valid <= 1'b0;
    else
      rsp_valid <= req_valid;
  end

  // A lock aimed at a locked region pulses refused too, so the host sees it changed nothing.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      refused <= 1'b0;
    else
      refused <= sec_req && locked_tgt && (req_cmd != CMD_READ); // R15
  end

  // =====================================================================
  // Read data
  // Data comes from flops so the host never sees the decode settle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rsp_hit   <= 1'b0;
      rsp_rdata <= ERASED_BYTE;
    end
    else
    begin
      rsp_hit   <= next_hit;
      rsp_rdata <= next_rdata; // R8 R9
    end
  end

  // =====================================================================
  // Main array decode
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      main_valid <= 1'b0;
    else
      main_valid <= main_req && main_hit; // R4
  end

  // Sector and offset follow every request; they mean something only beside main_valid.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      main_sector <= '0;
      main_offset <= '0;
    end
    else
    begin
      main_sector <= req_addr[SECTOR_BITS +: SECTOR_IDX_W]; // R2 R3
      main_offset <= req_addr[SECTOR_BITS-1:0]; // R3
    end
  end
endmodule
`default_nettype wire

/* File: tb/flash_address_map_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_address_map_asserts
  import flash_map_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic [1:0]  req_cmd,
  input wire logic [1:0]  req_space,
  input wire logic [23:0] req_addr,
  input wire logic [7:0]  rsp_rdata,
  input wire logic        main_valid,
  input wire logic [3:0]  lock_bits,
  input wire logic        refused
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic sfdp_rd, main_rq, lock_hit;
  assign sfdp_rd = req_valid && req_cmd == CMD_READ && req_space == SPACE_SFDP;
  assign main_rq = req_valid && req_space == SPACE_MAIN;
  assign lock_hit = req_valid && req_cmd == CMD_PROG && req_space == SPACE_SEC
    && req_addr[23:14] == 0 && req_addr[11:8] == 0 && lock_bits[req_addr[13:12]];
  sequence rd_at(a); sfdp_rd && req_addr == a; endsequence
  sig_byte_a: assert property (rd_at(8'h00) |=> rsp_rdata == SIG_B0) else $error("sig");
  erase_op_a: assert property (rd_at(8'h81) |=> rsp_rdata == ERASE4K_OP) else $error("op");
  sfdp_bound_a: assert property (sfdp_rd && |req_addr[23:8] |=> rsp_rdata == ERASED_BYTE)
    else $error("bound");
  range_end_a: assert property (main_rq && req_addr[23] |=> !main_valid) else $error("end");
  in_range_a: assert property (main_rq && !req_addr[23:22] |=> main_valid)
    else $error("miss");
  lock_sticky_a: assert property ((lock_bits & $past(lock_bits)) == $past(lock_bits))
    else $error("lock");
  factory_lock_a: assert property (lock_bits[0]) else $error("factory");
  locked_prog_a: assert property (lock_hit |=> refused) else $error("refuse");
endmodule
bind flash_address_map flash_address_map_asserts flash_address_map_asserts_inst
(
  .clk        (clk),
  .rst_n      (rst_n),
  .req_valid  (req_valid),
  .req_cmd    (req_cmd),
  .req_space  (req_space),
  .req_addr   (req_addr),
  .rsp_rdata  (rsp_rdata),
  .main_valid (main_valid),
  .lock_bits  (lock_bits),
  .refused    (refused)
);
`default_nettype wire

/* File: tb/host.sv */
`timescale 1ns/1ns
`default_nettype none
module host
  import flash_map_pkg::*;
(
  input  wire logic        clk,
  output logic             req_valid,
  output logic      [1:0]  req_cmd,
  output logic      [1:0]  req_space,
  output logic      [23:0] req_addr,
  output logic      [7:0]  req_wdata
);
  initial {req_valid, req_cmd, req_space, req_addr, req_wdata} = '0;
  task automatic send(input cmd_e c, input space_e s, input logic [23:0] a, input logic [7:0] d);
    @(negedge clk);
    {req_valid, req_cmd, req_space, req_addr, req_wdata} = {1'b1, c, s, a, d};
    @(negedge clk);
    // Released fields flip so a stale address can never pass for a fresh one.
    {req_valid, req_addr, req_wdata} = {1'b0, ~req_addr, ~req_wdata};
  endtask
endmodule
`default_nettype wire

/* File: tb/flash_address_map_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module flash_address_map_tb_top
  import flash_map_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, large_variant = 1'b0;
  logic        req_valid, rsp_valid, rsp_hit, main_valid, refused;
  logic [1:0]  req_cmd, req_space;
  logic [23:0] req_addr;
  logic [7:0]  req_wdata, rsp_rdata;
  logic [10:0] main_sector;
  logic [11:0] main_offset;
  logic [3:0]  lock_bits;
  int          fail_count = 0, total_checks = 0, cycles = 0;
  logic [15:0] rows [10] = '{16'h0053, 16'h0350, 16'h0501, 16'h0602, 16'h07FF,
    16'h0800, 16'h0B09, 16'h0C80, 16'h1304, 16'h8120};
  flash_address_map flash_address_map_inst
  (
    .clk           (clk),
    .rst_n         (rst_n),
    .large_variant (large_variant),
    .req_valid     (req_valid),
    .req_cmd       (req_cmd),
    .req_space     (req_space),
    .req_addr      (req_addr),
    .req_wdata     (req_wdata),
    .rsp_valid     (rsp_valid),
    .rsp_rdata     (rsp_rdata),
    .rsp_hit       (rsp_hit),
    .main_valid    (main_valid),
    .main_sector   (main_sector),
    .main_offset   (main_offset),
    .lock_bits     (lock_bits),
    .refused       (refused)
  );
  host host_inst
  (
    .clk       (clk),
    .req_valid (req_valid),
    .req_cmd   (req_cmd),
    .req_space (req_space),
    .req_addr  (req_addr),
    .req_wdata (req_wdata)
  );
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cycles == 2000) complete_run(1);
  task automatic complete_run(input int extra);
    fail_count += extra;
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rchk(input space_e s, input logic [23:0] a, input logic [9:0] e);
    host_inst.send(CMD_READ, s, a, 8'h00);
    `CHK("read", e, {rsp_valid, rsp_hit, rsp_rdata})
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i])
      rchk(SPACE_SFDP, 24'(rows[i][15:8]), {2'b11, rows[i][7:0]});
    rchk(SPACE_SFDP, 24'h00_0100, 10'h2FF);
    host_inst.send(CMD_PROG, SPACE_SEC, 24'h00_1010, 8'h3C);
    rchk(SPACE_SEC, 24'h00_1010, 10'h33C);
    host_inst.send(CMD_LOCK, SPACE_SEC, 24'h00_2000, 8'h00);
    `CHK("locks", 4'h5, lock_bits)
    host_inst.send(CMD_PROG, SPACE_SEC, 24'h00_2005, 8'h00);
    `CHK("refused", 1'b1, refused)
    rchk(SPACE_SEC, 24'h00_2005, 10'h3FF);
    host_inst.send(CMD_ERASE, SPACE_SEC, 24'h00_2000, 8'h00);
    `CHK("refused", 1'b1, refused)
    host_inst.send(CMD_ERASE, SPACE_SEC, 24'h00_1000, 8'h00);
    `CHK("refused", 1'b0, refused)
    rchk(SPACE_SEC, 24'h00_1010, 10'h3FF);
    rchk(SPACE_SEC, 24'h00_0003, 10'h350);
    rchk(SPACE_SEC, 24'h00_1100, 10'h2FF);
    host_inst.send(CMD_READ, SPACE_MAIN, 24'h3F_FFFF, 8'h00);
    `CHK("main", {2'h3, 23'h3F_FFFF}, {main_valid, rsp_hit, main_sector, main_offset})
    host_inst.send(CMD_READ, SPACE_MAIN, 24'h40_0000, 8'h00);
    `CHK("main", 2'h0, {main_valid, rsp_hit})
    host_inst.send(CMD_READ, SPACE_MAIN, 24'h80_0000, 8'h00);
    `CHK("main", 1'b0, main_valid)
    @(negedge clk);
    {rst_n, large_variant} = 2'h1;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    host_inst.send(CMD_READ, SPACE_MAIN, 24'h7F_FFFF, 8'h00);
    `CHK("main", {2'h3, 23'h7F_FFFF}, {main_valid, rsp_hit, main_sector, main_offset})
    host_inst.send(CMD_READ, SPACE_MAIN, 24'h80_0000, 8'h00);
    `CHK("main", 2'h0, {main_valid, rsp_hit})
    complete_run(0);
  end
endmodule
`default_nettype wire
